//--- sbs_pkg.sv
/*
  Package for the set-byte and sleep execution block: field layout,
  reset values and state encodings.
  Assumes a single core clock and no other consumers than sbs_exec.
*/
package sbs_pkg;
  // Data memory address layout
  localparam int          ADDR_W        = 12;
  localparam int          FILE_W        = 8;
  localparam int          BANK_W        = 4;
  // Value written by the set-byte instruction
  localparam logic [7:0]  ALL_ONES      = 8'hff;
  // Access bank split: low part maps to bank 0, high part to bank 15
  localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
  localparam logic [3:0]  ACCESS_HI_BNK = 4'hf;
  localparam logic [3:0]  ACCESS_LO_BNK = 4'h0;
  // Highest file operand that goes indexed in extended mode
  localparam logic [7:0]  INDEXED_MAX   = 8'h5f;
  // Status flag values after reset (both read as one after power-on)
  localparam logic        PWRDN_RESET   = 1'b1;
  localparam logic        TO_RESET      = 1'b1;
  // Watchdog counter and postscaler widths
  localparam int          DOG_W         = 8;
  localparam int          POST_W        = 16;
  // Interrupt status bit positions
  localparam int          EV_SET        = 0;
  localparam int          EV_SLEEP      = 1;
  localparam int          EV_WAKE_DOG   = 2;
  localparam int          EV_W          = 3;
  localparam logic [2:0]  MASK_RESET    = 3'h0;

  // Core run state, one-hot
  typedef enum logic [1:0] {
    ST_RUN   = 2'b01,
    ST_SLEEP = 2'b10
  } sbs_state_e;
endpackage

//--- sbs_exec.sv
/*
  Execution logic for the set-byte and low-power entry instructions.
  Decoded instruction strobes arrive from the core decode stage, one cycle
  each; the block drives a data memory write port, the sleep status flags,
  the watchdog counter and postscaler, and the oscillator run enable.
  Assumes the decode stage stalls fetch while asleep via coreHalted.
*/
// Strobed register access and the register offsets were decided locally.
// Summary of operation
// RULE_01 - Bank bit clear: set-byte addresses the fixed access bank.
// RULE_02 - Bank bit set: bank select register picks the RAM bank.
// RULE_03 - Set-byte writes all ones; arithmetic flags stay untouched.
// RULE_04 - Sleep instruction clears the power-down flag.
// RULE_05 - Sleep instruction sets the time-out flag.
// RULE_06 - Sleep instruction zeroes watchdog counter and postscaler.
// RULE_07 - After sleep the core halts with the oscillator stopped.
// RULE_08 - Wake by watchdog expiry clears the time-out flag.
// RULE_09 - Extended mode, bank bit clear, operand up to 95: indexed offset addressing.
// RULE_10 - Both instructions take one word and one cycle, no stall.
`timescale 1ns/1ps
module sbs_exec #(
  parameter int DOG_W  = sbs_pkg::DOG_W,
  parameter int POST_W = sbs_pkg::POST_W
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      resetn,
  // Decoded instruction
  input  wire logic                      setAllOnesOp,
  input  wire logic                      sleepOp,
  input  wire logic [7:0]                fileOperand,
  input  wire logic                      bankAccessBit,
  // Core context
  input  wire logic [3:0]                bankSelectReg,
  input  wire logic                      extendedEnable,
  input  wire logic [11:0]               indexBase,
  input  wire logic                      wakeEvent,
  input  wire logic                      watchdogTick,
  // Data memory write port
  output logic                           memWrite,
  output logic [11:0]                    memAddr,
  output logic [7:0]                     memWData,
  // Status and power
  output logic                           powerDownFlag,
  output logic                           timeoutFlag,
  output logic                           oscRun,
  output logic                           coreHalted,
  output logic [DOG_W-1:0]               watchdogCounter,
  output logic [POST_W-1:0]              watchdogPostscaler,
  // Register port
  input  wire logic [1:0]                regAddr,
  input  wire logic [7:0]                regWData,
  input  wire logic                      regWrite,
  input  wire logic                      regRead,
  output logic [7:0]                     regRData,
  output logic                           irq
);

  ////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [1:0] OFF_STATUS = 2'h0;
  localparam logic [1:0] OFF_MASK   = 2'h1;
  localparam logic [1:0] OFF_FLAGS  = 2'h2;

  typedef struct packed {
    sbs_pkg::sbs_state_e       state;
    logic                      memWrite;
    logic [11:0]               memAddr;
    logic [7:0]                memWData;
    logic                      pwrDn;
    logic                      to;
    logic [DOG_W-1:0]          dog;
    logic [POST_W-1:0]         post;
    logic [sbs_pkg::EV_W-1:0]  status;
    logic [sbs_pkg::EV_W-1:0]  mask;
    logic [7:0]                rdata;
  } sbs_state_s;

  sbs_state_s state_reg;
  sbs_state_s state_next;

  ////////////////////////////////////////////////////////////////////////
  // Effective address of a file operand
  function automatic logic [11:0] effAddr(input logic [7:0] f, input logic a,
                                          input logic [3:0] bankSel, input logic ext,
                                          input logic [11:0] base);
    logic [11:0] r;
    r = {bankSel, f};                                            // RULE_02
    if (!a && ext && f <= sbs_pkg::INDEXED_MAX)
      r = 12'(base + {4'h0, f});                                 // RULE_09
    else if (!a && f < sbs_pkg::ACCESS_SPLIT)
      r = {sbs_pkg::ACCESS_LO_BNK, f};                           // RULE_01
    else if (!a)
      r = {sbs_pkg::ACCESS_HI_BNK, f};                           // RULE_01
    return r;
  endfunction

  logic                      asleep;
  logic                      wdtExpire;
  logic [sbs_pkg::EV_W-1:0]  events;

  assign asleep = (state_reg.state == sbs_pkg::ST_SLEEP);
  assign wdtExpire = watchdogTick && (&state_reg.dog) && (&state_reg.post);

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    state_next = state_reg;
    events = '0;
    state_next.memWrite = 1'b0;
    state_next.rdata = 8'h00;
    // Watchdog advances on its tick; postscaler carries into the counter
    if (watchdogTick)
    begin
      state_next.post = state_reg.post + 1'b1;
      if (&state_reg.post)
        state_next.dog = state_reg.dog + 1'b1;
    end
    case (state_reg.state)
      sbs_pkg::ST_RUN:
      begin
        // Single cycle, no stall inserted
        if (setAllOnesOp)                                        // RULE_10
        begin
          state_next.memWrite = 1'b1;
          state_next.memAddr = effAddr(fileOperand, bankAccessBit,
                                       bankSelectReg, extendedEnable, indexBase);
          state_next.memWData = sbs_pkg::ALL_ONES;               // RULE_03
          events[sbs_pkg::EV_SET] = 1'b1;
        end
        else if (sleepOp)                                        // RULE_10
        begin
          state_next.pwrDn = 1'b0;                               // RULE_04
          state_next.to = 1'b1;                                  // RULE_05
          state_next.dog = '0;                                   // RULE_06
          state_next.post = '0;                                  // RULE_06
          state_next.state = sbs_pkg::ST_SLEEP;                  // RULE_07
          events[sbs_pkg::EV_SLEEP] = 1'b1;
        end
      end
      sbs_pkg::ST_SLEEP:
      begin
        // Watchdog wins over a simultaneous other wake source
        if (wdtExpire)
        begin
          state_next.to = 1'b0;                                  // RULE_08
          state_next.dog = '0;
          state_next.post = '0;
          state_next.state = sbs_pkg::ST_RUN;
          events[sbs_pkg::EV_WAKE_DOG] = 1'b1;
        end
        else if (wakeEvent)
          state_next.state = sbs_pkg::ST_RUN;
      end
      default:
        state_next.state = sbs_pkg::ST_RUN;
    endcase
    // Register port: status is write one to clear, mask is a plain write; new events win over the clear
    if (regWrite && regAddr == OFF_STATUS)
      state_next.status = state_reg.status & ~regWData[sbs_pkg::EV_W-1:0];
    else if (regWrite && regAddr == OFF_MASK)
      state_next.mask = regWData[sbs_pkg::EV_W-1:0];
    state_next.status = state_next.status | events;
    if (regRead && regAddr == OFF_STATUS)
      state_next.rdata = {5'h00, state_reg.status};
    else if (regRead && regAddr == OFF_MASK)
      state_next.rdata = {5'h00, state_reg.mask};
    else if (regRead && regAddr == OFF_FLAGS)
      state_next.rdata = {5'h00, asleep, state_reg.to, state_reg.pwrDn};
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_reg.state    <= sbs_pkg::ST_RUN;
      state_reg.memWrite <= 1'b0;
      state_reg.memAddr  <= '0;
      state_reg.memWData <= '0;
      state_reg.pwrDn    <= sbs_pkg::PWRDN_RESET;
      state_reg.to       <= sbs_pkg::TO_RESET;
      state_reg.dog      <= '0;
      state_reg.post     <= '0;
      state_reg.status   <= '0;
      state_reg.mask     <= sbs_pkg::MASK_RESET;
      state_reg.rdata    <= 8'h00;
    end
    else
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs; oscillator gated off whole time asleep
  assign memWrite           = state_reg.memWrite;
  assign memAddr            = state_reg.memAddr;
  assign memWData           = state_reg.memWData;
  assign powerDownFlag      = state_reg.pwrDn;
  assign timeoutFlag        = state_reg.to;
  assign oscRun             = !asleep;                           // RULE_07
  assign coreHalted         = asleep;                            // RULE_07
  assign watchdogCounter    = state_reg.dog;
  assign watchdogPostscaler = state_reg.post;
  assign regRData           = state_reg.rdata;
  assign irq                = |(state_reg.status & state_reg.mask);

endmodule // sbs_exec

//--- sbs_exec_properties.sv
/* Port checker for sbs_exec.
   Assumes the bind below reaches every sbs_exec instance. */
`timescale 1ns/1ps
module sbs_exec_chk #(parameter int DOG_W = 8, parameter int POST_W = 16) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              resetn,
  // Instruction side
  input wire logic              setAllOnesOp,
  input wire logic              sleepOp,
  input wire logic [7:0]        fileOperand,
  input wire logic              bankAccessBit,
  input wire logic [3:0]        bankSelectReg,
  input wire logic              extendedEnable,
  input wire logic [11:0]       indexBase,
  input wire logic              watchdogTick,
  // Results
  input wire logic              memWrite,
  input wire logic [11:0]       memAddr,
  input wire logic [7:0]        memWData,
  input wire logic              powerDownFlag,
  input wire logic              timeoutFlag,
  input wire logic              oscRun,
  input wire logic              coreHalted,
  input wire logic [DOG_W-1:0]  watchdogCounter,
  input wire logic [POST_W-1:0] watchdogPostscaler
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Ops count only while running; set-byte wins a tie
  wire setGo = setAllOnesOp && !coreHalted;
  wire slpGo = sleepOp && !setAllOnesOp && !coreHalted;
  wire lowAcc = setGo && !bankAccessBit && !extendedEnable && fileOperand < 8'h60;
  wire idxAcc = setGo && !bankAccessBit && extendedEnable && fileOperand <= 8'h5f;
  wire hiAcc = setGo && !bankAccessBit && fileOperand >= 8'h60;
  chk_access_high: assert property (hiAcc |=> memAddr == {4'hf, $past(fileOperand)})
    else $error("upper access bank address wrong");
  chk_set_ones: assert property (setGo |=> memWrite && memWData == 8'hff)
    else $error("set-byte write missing");
  chk_bank_addr: assert property (setGo && bankAccessBit |=> memAddr == {$past(bankSelectReg), $past(fileOperand)})
    else $error("banked address wrong");
  chk_access_low: assert property (lowAcc |=> memAddr == {4'h0, $past(fileOperand)})
    else $error("access bank address wrong");
  chk_indexed_addr: assert property (idxAcc |=> memAddr == $past(indexBase) + {4'h0, $past(fileOperand)})
    else $error("indexed address wrong");
  chk_sleep_flags: assert property (slpGo |=> !powerDownFlag && timeoutFlag)
    else $error("sleep flags wrong");
  chk_sleep_wdt: assert property (slpGo |=> watchdogCounter == 0 && watchdogPostscaler == 0)
    else $error("watchdog not cleared");
  chk_sleep_halt: assert property (slpGo |=> coreHalted && !oscRun)
    else $error("core not halted");
  chk_wdt_wake: assert property (coreHalted && watchdogTick && &watchdogCounter && &watchdogPostscaler |=> !timeoutFlag && !coreHalted)
    else $error("watchdog wake wrong");
  chk_one_cycle: assert property (memWrite |-> $past(setGo))
    else $error("stray memory write");
  // Main scenarios reached
  cov_set: cover property (setGo ##1 setGo);
  cov_sleep: cover property (slpGo);
  cov_wake: cover property (coreHalted ##1 !coreHalted && !timeoutFlag);
endmodule // sbs_exec_chk
bind sbs_exec sbs_exec_chk #(.DOG_W(DOG_W), .POST_W(POST_W)) i_sbs_exec_chk (.*);

//--- set_byte_and_sleep_exec_tb.sv
/* Self-checking bench for sbs_exec.
   Assumes watchdog widths of 2 bits so a watchdog expiry is short. */
`timescale 1ns/1ps
module set_byte_and_sleep_exec_tb;
  logic clk = 1'h0, resetn = 1'h0, setAllOnesOp = 1'h0, sleepOp = 1'h0, bankAccessBit = 1'h0;
  logic extendedEnable = 1'h0, wakeEvent = 1'h0, watchdogTick = 1'h0, regWrite = 1'h0;
  logic regRead = 1'h0, memWrite, powerDownFlag, timeoutFlag, oscRun, coreHalted, irq;
  logic [7:0] fileOperand = 8'h0, regWData = 8'h0, memWData, regRData;
  logic [3:0] bankSelectReg = 4'h0;
  logic [11:0] indexBase = 12'h0, memAddr;
  logic [1:0] regAddr = 2'h0, watchdogCounter, watchdogPostscaler;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  // Tiny counters keep the expiry to 16 ticks
  sbs_exec #(.DOG_W(2), .POST_W(2)) i_sbs_exec (.*);
  always #2 clk = ~clk;
  ////////////////////////////////////////
  task automatic close_out();
    $display("TB counts: %0d errors, %0d compared", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk) {regRead, regAddr} <= {1'h1, a};
    @(posedge clk) regRead <= 1'h0;
    #1 chk(nm, 12'(exp), 12'(regRData));
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk) {regWrite, regAddr, regWData} <= {1'h1, a, d};
    @(posedge clk) regWrite <= 1'h0;
  endtask
  ////////////////////////////////////////
  // Back-to-back set-byte over every addressing path
  task automatic t_set_byte();
    logic [37:0] cs [6] = '{{1'h1, 4'h5, 1'h0, 12'h0, 8'h3c, 12'h53c},
      {1'h0, 4'h5, 1'h0, 12'h0, 8'h20, 12'h020}, {1'h0, 4'h5, 1'h0, 12'h0, 8'h80, 12'hf80},
      {1'h0, 4'h0, 1'h1, 12'hfa0, 8'h5f, 12'hfff}, {1'h0, 4'h0, 1'h1, 12'hfa0, 8'h60, 12'hf60},
      {1'h1, 4'ha, 1'h1, 12'hfa0, 8'h10, 12'ha10}};
    for (int i = 0; i <= 6; i++)
    begin
      @(posedge clk) setAllOnesOp <= (i < 6);
      if (i < 6)
        {bankAccessBit, bankSelectReg, extendedEnable, indexBase, fileOperand} <= cs[i][37:12];
      #1;
      if (i > 0)
      begin
        chk("memWrite", 12'h1, 12'(memWrite));
        chk("memAddr", cs[i-1][11:0], memAddr);
        chk("memWData", 12'hff, 12'(memWData));
      end
    end
  endtask
  // Masking, raising and clearing the interrupt; unmapped slot
  task automatic t_irq();
    rd(2'h0, 8'h01, "status");
    chk("irqMasked", 12'h0, 12'(irq));
    wr(2'h1, 8'h01);
    rd(2'h3, 8'h00, "unmapped");
    chk("irqOn", 12'h1, 12'(irq));
    wr(2'h0, 8'h01);
    wr(2'h3, 8'hff);
    rd(2'h0, 8'h00, "statusClr");
    chk("irqOff", 12'h0, 12'(irq));
  endtask
  // Sleep entry with the watchdog already counting
  task automatic t_sleep();
    repeat (3) @(posedge clk) watchdogTick <= 1'h1;
    @(posedge clk) {watchdogTick, sleepOp} <= 2'h1;
    @(posedge clk) sleepOp <= 1'h0;
    #1 chk("powerDown", 12'h0, 12'(powerDownFlag));
    chk("timeout", 12'h1, 12'(timeoutFlag));
    chk("wdt", 12'h0, {watchdogCounter, 8'h0, watchdogPostscaler});
    chk("halt", 12'h2, {coreHalted, oscRun});
  endtask
  task automatic t_wake();
    int k = 0;
    @(posedge clk) setAllOnesOp <= 1'h1;
    @(posedge clk) setAllOnesOp <= 1'h0;
    #1 chk("asleepWrite", 12'h0, 12'(memWrite));
    rd(2'h2, 8'h06, "flags");
    @(posedge clk) wakeEvent <= 1'h1;
    @(posedge clk) wakeEvent <= 1'h0;
    #1 chk("wakeEvent", 12'h3, {coreHalted, oscRun, timeoutFlag});
    t_sleep();
    @(posedge clk) watchdogTick <= 1'h1;
    while (coreHalted === 1'h1 && k < 40)
    begin
      @(posedge clk);
      #1 k++;
    end
    @(posedge clk) watchdogTick <= 1'h0;
    #1 chk("wdtWake", 12'h2, {coreHalted, oscRun, timeoutFlag});
    rd(2'h0, 8'h06, "wakeStatus");
  endtask
  ////////////////////////////////////////
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      close_out();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk);
    resetn <= 1'h1;
    t_set_byte();
    t_irq();
    t_sleep();
    t_wake();
    close_out();
  end
endmodule // set_byte_and_sleep_exec_tb
